/* core/flash_status_pkg.sv */
// Package holding commands, field layout, reset values and types of the flash status logic.
package flash_status_pkg;
	localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] CMD_VOL_ENABLE   = 8'h50;
	localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
	localparam logic [7:0] CMD_WRITE_OFF    = 8'h04;
	localparam logic [7:0] CMD_READ_ONE     = 8'h05;
	localparam logic [7:0] CMD_READ_TWO     = 8'h35;
	localparam logic [7:0] CMD_READ_THREE   = 8'h33;
	localparam logic [7:0] CMD_PAUSE        = 8'h75;
	localparam logic [7:0] CMD_RESUME       = 8'h7A;
	localparam logic [7:0] CMD_SOFT_RESET   = 8'h99;
	// Bit positions inside the status bytes.
	localparam int PM_LOWER_BIT = 7;
	localparam int PM_UPPER_BIT = 0;
	localparam int FOUR_LANE_BIT = 1;
	localparam int LOCK0_BIT = 2;
	localparam int PAUSED_BIT = 7;
	// Writable fields of the first two bytes and the one-time lock field.
	localparam logic [7:0] ONE_WR_MASK  = 8'hFC;
	localparam logic [7:0] TWO_WR_MASK  = 8'h43;
	localparam logic [7:0] LOCK_MASK    = 8'h3C;
	localparam logic [7:0] ONE_RESET    = 8'h00;
	localparam logic [7:0] TWO_RESET    = 8'h04;
	localparam logic [7:0] THREE_RESET  = 8'h00;
	// Legacy dummy figures when the read wait count is zero, and the mode figures used at every count.
	localparam logic [3:0] LEGACY_DUMMY    = 4'h8;
	localparam logic [3:0] DUAL_IO_MODE    = 4'h4;
	localparam logic [3:0] QUAD_IO_MODE    = 4'h2;
	localparam logic [3:0] QUAD_IO_DUMMY   = 4'h4;

	typedef enum logic [2:0] {RK_PLAIN, RK_FAST, RK_DUAL_OUT, RK_DUAL_IO, RK_QUAD_OUT, RK_QUAD_IO} read_kind_type;
	typedef enum logic [1:0] {ST_CMD, ST_DATA} link_state_type;

	typedef struct packed {
		logic [3:0] mode;
		logic [3:0] dummy;
	} wait_type;

	typedef struct packed {
		logic                 sck_s1;
		logic                 sck_s2;
		logic                 sck_d;
		logic                 cs_s1;
		logic                 cs_s2;
		logic                 cs_d;
		logic                 si_s1;
		logic                 si_s2;
		logic                 wp_s1;
		logic                 wp_s2;
		link_state_type       lstate;
		logic [6:0]           shift;
		logic [2:0]           bitcnt;
		logic [1:0]           nbytes;
		logic [7:0]           cmd;
		logic [2:0][7:0]      wbuf;
		logic                 reading;
		logic [7:0]           outsh;
		logic                 so;
		logic [7:0]           nv_one;
		logic [7:0]           nv_two;
		logic [7:0]           vol_one;
		logic [7:0]           vol_two;
		logic [7:0]           three;
		logic                 write_latch_flag;
		logic                 vwel;
		logic                 paused;
		wait_type             rw;
	} state_type;
endpackage

/* core/flash_status_protection_config.sv */
// Status byte protection, suspend flag, lock bits, lane enable and read wait logic of a serial flash.
`timescale 1ns/1ps
module flash_status_protection_config (
	// Clock and reset
	input  wire logic                           sys_clk_i,
	input  wire logic                           rst_i,
	// Serial link pins
	input  wire logic                           sck_i,
	input  wire logic                           cs_n_i,
	input  wire logic                           si_i,
	input  wire logic                           protect_pin_i,
	output logic                                so_o,
	output logic                                so_oe_o,
	// Array side
	input  wire logic                           busy_i,
	input  wire logic                           pe_req_i,
	input  wire logic                           pe_region_protected_i,
	output logic                                pe_start_o,
	input  flash_status_pkg::read_kind_type     read_kind_i,
	output flash_status_pkg::wait_type          read_wait_o,
	// Configuration state
	output logic                                four_lane_enable_o,
	output logic                                control_pins_active_o,
	output logic [3:0]                          otp_lock_bits_o,
	output logic                                paused_operation_flag_o,
	output logic                                write_latch_flag_o
);
	flash_status_pkg::state_type st;
	flash_status_pkg::state_type next_st;
	logic       sck_rise;
	logic       sck_fall;
	logic       cs_rise;
	logic       wp_eff;
	logic       write_done;
	logic [7:0] byte_in;
	logic [7:0] rd_cmd;
	logic [7:0] one_view;
	logic [7:0] two_view;

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val, input logic [7:0] mask);
		merge = (old & ~mask) | (val & mask);
	endfunction

	function automatic logic write_allowed(input logic upper, input logic lower, input logic pin);
		write_allowed = ({upper, lower} == 2'b00) || (({upper, lower} == 2'b01) && pin);
	endfunction

	// Mode cycles are not latency cycles, so a nonzero count leaves them in place.
	function automatic flash_status_pkg::wait_type wait_for(input flash_status_pkg::read_kind_type kind,
			input logic [3:0] count);
		flash_status_pkg::wait_type w;
		w.mode = 4'h0;
		w.dummy = (count != 4'h0) ? count : flash_status_pkg::LEGACY_DUMMY;
		case (kind)
			flash_status_pkg::RK_PLAIN: begin
				w.dummy = 4'h0;
			end
			flash_status_pkg::RK_DUAL_IO: begin
				w.mode = flash_status_pkg::DUAL_IO_MODE;
				if (count == 4'h0) begin
					w.dummy = 4'h0;
				end
			end
			flash_status_pkg::RK_QUAD_IO: begin
				w.mode = flash_status_pkg::QUAD_IO_MODE;
				if (count == 4'h0) begin
					w.dummy = flash_status_pkg::QUAD_IO_DUMMY;
				end
			end
			default: begin
			end
		endcase
		return w;
	endfunction

	assign sck_rise = st.sck_s2 && !st.sck_d;
	assign sck_fall = !st.sck_s2 && st.sck_d;
	assign cs_rise = st.cs_s2 && !st.cs_d;
	// While lanes are enabled the protect pin is data, so its protect role is void.
	assign wp_eff = st.vol_two[flash_status_pkg::FOUR_LANE_BIT] ? 1'b1 : st.wp_s2;
	assign write_done = cs_rise && (st.lstate == flash_status_pkg::ST_DATA) && (st.bitcnt == 3'h0)
		&& (st.cmd == flash_status_pkg::CMD_WRITE_STATUS);
	assign byte_in = {st.shift, st.si_s2};
	assign rd_cmd = (st.lstate == flash_status_pkg::ST_CMD) ? byte_in : st.cmd;
	assign one_view = {st.vol_one[7:2], st.write_latch_flag || st.vwel, busy_i};
	assign two_view = {st.paused, st.vol_two[6], st.nv_two[5:2], st.vol_two[1:0]};

	always_comb begin
		next_st = st;
		next_st.sck_s1 = sck_i;
		next_st.sck_s2 = st.sck_s1;
		next_st.sck_d = st.sck_s2;
		next_st.cs_s1 = cs_n_i;
		next_st.cs_s2 = st.cs_s1;
		next_st.cs_d = st.cs_s2;
		next_st.si_s1 = si_i;
		next_st.si_s2 = st.si_s1;
		next_st.wp_s1 = protect_pin_i;
		next_st.wp_s2 = st.wp_s1;
		next_st.rw = wait_for(read_kind_i, st.three[3:0]);
		if (st.cs_s2) begin
			next_st.lstate = flash_status_pkg::ST_CMD;
			next_st.bitcnt = 3'h0;
			next_st.nbytes = 2'h0;
			next_st.reading = 1'b0;
		end else if (sck_rise) begin
			next_st.shift = byte_in[6:0];
			next_st.bitcnt = st.bitcnt + 3'h1;
			if (st.bitcnt == 3'h7) begin
				case (rd_cmd)
					flash_status_pkg::CMD_READ_ONE: next_st.outsh = one_view;
					flash_status_pkg::CMD_READ_TWO: next_st.outsh = two_view;
					flash_status_pkg::CMD_READ_THREE: next_st.outsh = st.three;
					default: next_st.outsh = 8'h00;
				endcase
				if (st.lstate == flash_status_pkg::ST_CMD) begin
					next_st.cmd = byte_in;
					next_st.lstate = flash_status_pkg::ST_DATA;
					next_st.reading = (byte_in == flash_status_pkg::CMD_READ_ONE)
						|| (byte_in == flash_status_pkg::CMD_READ_TWO)
						|| (byte_in == flash_status_pkg::CMD_READ_THREE);
				end else if (st.nbytes != 2'h3) begin
					next_st.wbuf[st.nbytes] = byte_in;
					next_st.nbytes = st.nbytes + 2'h1;
				end
			end
		end else if (sck_fall && st.reading) begin
			// Rotating keeps re-sending the byte, refreshed at every byte boundary.
			next_st.so = st.outsh[7];
			next_st.outsh = {st.outsh[6:0], st.outsh[7]};
		end
		// Commands act only when chip select rises on a whole byte.
		if (cs_rise && (st.lstate == flash_status_pkg::ST_DATA) && (st.bitcnt == 3'h0)) begin
			case (st.cmd)
				flash_status_pkg::CMD_WRITE_ENABLE: begin
					if (st.nbytes == 2'h0) next_st.write_latch_flag = 1'b1;
				end
				flash_status_pkg::CMD_VOL_ENABLE: begin
					if (st.nbytes == 2'h0) next_st.vwel = 1'b1;
				end
				flash_status_pkg::CMD_WRITE_OFF: begin
					next_st.write_latch_flag = 1'b0;
					next_st.vwel = 1'b0;
				end
				flash_status_pkg::CMD_PAUSE: begin
					next_st.paused = 1'b1;
				end
				flash_status_pkg::CMD_RESUME: begin
					next_st.paused = 1'b0;
				end
				flash_status_pkg::CMD_SOFT_RESET: begin
					next_st.write_latch_flag = 1'b0;
					next_st.vwel = 1'b0;
					if (st.vol_two[flash_status_pkg::PM_UPPER_BIT] && !st.vol_one[flash_status_pkg::PM_LOWER_BIT]) begin
						next_st.vol_two[flash_status_pkg::PM_UPPER_BIT] = 1'b0;
						next_st.nv_two[flash_status_pkg::PM_UPPER_BIT] = 1'b0;
						next_st.nv_one[flash_status_pkg::PM_LOWER_BIT] = 1'b0;
					end
				end
				flash_status_pkg::CMD_WRITE_STATUS: begin
					if (st.nbytes != 2'h0 && (st.write_latch_flag || st.vwel)) begin
						if (write_allowed(st.vol_two[flash_status_pkg::PM_UPPER_BIT],
								st.vol_one[flash_status_pkg::PM_LOWER_BIT], wp_eff)) begin
							next_st.vol_one = merge(st.vol_one, st.wbuf[0], flash_status_pkg::ONE_WR_MASK);
							if (st.write_latch_flag) begin
								next_st.nv_one = merge(st.nv_one, st.wbuf[0], flash_status_pkg::ONE_WR_MASK);
							end
							if (st.nbytes >= 2'h2) begin
								next_st.vol_two = merge(st.vol_two, st.wbuf[1], flash_status_pkg::TWO_WR_MASK);
								if (st.write_latch_flag) begin
									next_st.nv_two = merge(st.nv_two, st.wbuf[1], flash_status_pkg::TWO_WR_MASK);
									next_st.nv_two = next_st.nv_two | (st.wbuf[1] & flash_status_pkg::LOCK_MASK);
								end
							end
						end
						if (st.nbytes == 2'h3 && st.vwel) begin
							next_st.three = st.wbuf[2];
						end
					end
					next_st.write_latch_flag = 1'b0;
					next_st.vwel = 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st <= '0;
			st.sck_s1 <= 1'b0;
			st.cs_s1 <= 1'b1;
			st.cs_s2 <= 1'b1;
			st.cs_d <= 1'b1;
			st.wp_s1 <= 1'b1;
			st.wp_s2 <= 1'b1;
			st.lstate <= flash_status_pkg::ST_CMD;
			// This reset stands for a power cycle, so a lock-down pair comes back as 00.
			// Stored bits are not kept across it either, a limitation of this model.
			st.nv_one <= flash_status_pkg::ONE_RESET;
			st.nv_two <= flash_status_pkg::TWO_RESET;
			st.vol_one <= flash_status_pkg::ONE_RESET;
			st.vol_two <= flash_status_pkg::TWO_RESET;
			st.three <= flash_status_pkg::THREE_RESET;
			st.rw <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign so_o = st.so;
	assign so_oe_o = st.reading && !st.cs_s2;
	assign pe_start_o = pe_req_i && !pe_region_protected_i;
	assign read_wait_o = st.rw;
	assign four_lane_enable_o = st.vol_two[flash_status_pkg::FOUR_LANE_BIT];
	assign control_pins_active_o = !st.vol_two[flash_status_pkg::FOUR_LANE_BIT];
	assign otp_lock_bits_o = st.nv_two[5:2];
	assign paused_operation_flag_o = st.paused;
	assign write_latch_flag_o = st.write_latch_flag || st.vwel;

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	// The command checks look at the stored state one cycle after a command lands at chip select rise; the lock, wait and array checks do not.
	chk_lock_down: assert property (write_done && st.vol_two[0] |=> $stable(st.vol_one) && $stable(st.nv_two))
		else $error("status written while locked");
	chk_pin_lock: assert property (write_done && !st.vol_two[0] && st.vol_one[7] && !wp_eff
			|=> $stable(st.vol_one) && $stable(st.vol_two))
		else $error("status written with protect pin low");
	chk_pin_free: assert property (write_done && st.write_latch_flag && st.nbytes != 2'h0 && wp_eff
			&& !st.vol_two[0] && st.vol_one[7] |=> st.nv_one[7:2] == $past(st.wbuf[0][7:2]))
		else $error("status write refused with protect pin high");
	chk_free_write: assert property (write_done && st.write_latch_flag && st.nbytes != 2'h0 && st.vol_two[0] == 1'b0
			&& st.vol_one[7] == 1'b0 |=> st.nv_one[7:2] == $past(st.wbuf[0][7:2]))
		else $error("permitted status write not stored");
	chk_latch_clear: assert property (write_done |=> !st.write_latch_flag && !st.vwel)
		else $error("write latch left set after write-status");
	chk_nv_kept: assert property (write_done && !st.write_latch_flag |=> $stable(st.nv_one) && $stable(st.nv_two))
		else $error("volatile status write changed stored bits");
	chk_latch_set: assert property (cs_rise && st.cmd == flash_status_pkg::CMD_WRITE_ENABLE
			&& st.nbytes == 2'h0 && st.lstate == flash_status_pkg::ST_DATA && st.bitcnt == 3'h0 |=> st.write_latch_flag)
		else $error("write enable did not set the latch");
	chk_paused_kept: assert property (write_done |=> st.paused == $past(st.paused))
		else $error("write-status changed paused flag");
	chk_pause_set: assert property (cs_rise && st.cmd == flash_status_pkg::CMD_PAUSE && st.lstate
			== flash_status_pkg::ST_DATA && st.bitcnt == 3'h0 |=> st.paused)
		else $error("suspend did not set paused flag");
	chk_resume_clear: assert property (cs_rise && st.cmd == flash_status_pkg::CMD_RESUME && st.lstate
			== flash_status_pkg::ST_DATA && st.bitcnt == 3'h0 |=> !st.paused)
		else $error("resume did not clear paused flag");
	chk_soft_unlock: assert property (cs_rise && st.cmd == flash_status_pkg::CMD_SOFT_RESET && st.vol_two[0]
			&& !st.vol_one[7] && st.lstate == flash_status_pkg::ST_DATA && st.bitcnt == 3'h0
			|=> !st.vol_two[0] && !st.nv_two[0])
		else $error("software reset kept lock-down mode");
	chk_lock_sticky: assert property (($past(st.nv_two[5:2]) & ~st.nv_two[5:2]) == 4'h0)
		else $error("lock bit cleared");
	chk_lock0_set: assert property (st.nv_two[2])
		else $error("lock bit zero not set");
	chk_third_write: assert property (write_done && st.vwel && st.nbytes == 2'h3
			|=> st.three == $past(st.wbuf[2]))
		else $error("third byte not written");
	chk_plain_wait: assert property (read_kind_i == flash_status_pkg::RK_PLAIN
			|=> read_wait_o.mode == 4'h0 && read_wait_o.dummy == 4'h0)
		else $error("plain read given wait cycles");
	chk_legacy_wait: assert property (read_kind_i == flash_status_pkg::RK_QUAD_IO && st.three[3:0] == 4'h0
			|=> read_wait_o.mode == 4'h2 && read_wait_o.dummy == 4'h4)
		else $error("wrong legacy quad wait");
	chk_count_wait: assert property (read_kind_i == flash_status_pkg::RK_FAST && st.three[3:0] != 4'h0
			|=> read_wait_o.dummy == $past(st.three[3:0]))
		else $error("wait count not applied");
	chk_pe_gate: assert property (pe_region_protected_i |-> !pe_start_o)
		else $error("program or erase started in protected region");

	cov_write_ok: cover property (write_done && st.write_latch_flag ##1 st.nv_one != $past(st.nv_one));
	cov_pause: cover property (st.paused ##[1:300] !st.paused);
	cov_lanes: cover property (!four_lane_enable_o ##1 four_lane_enable_o);
	cov_pin_lock: cover property (write_done && st.vol_one[7] && !wp_eff);
	cov_third_byte: cover property (write_done && st.vwel && st.nbytes == 2'h3);
endmodule

/* testbench/spi_host_model.sv */
// Behavioural serial host that frames commands and status reads for the flash status block.
`timescale 1ns/1ps
module spi_host_model (
	// Clock
	input  wire logic clk_i,
	// Serial link
	output logic      sck_o,
	output logic      cs_n_o,
	output logic      si_o,
	input  wire logic so_i
);
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end
	// Mode 0 framing: the clock idles low and each half period is four system clocks (80 ns period).
	// Read bits are taken just before the next falling edge, long after the block has settled its output.
	task automatic xfer(input logic [31:0] tx, input int nb, output logic [7:0] rx);
		rx = 8'h00;
		cs_n_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		for (int i = 0; i < nb * 8; i++) begin
			si_o <= tx[31 - i];
			repeat (4) @(posedge clk_i);
			sck_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			if (i >= 8) rx = {rx[6:0], so_i};
			sck_o <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
		cs_n_o <= 1'b1;
		// The host inverts the data line after the frame, so it does not keep showing the last bit.
		si_o <= ~si_o;
		repeat (8) @(posedge clk_i);
	endtask
endmodule

/* testbench/testbench.sv */
// Self-checking testbench of the flash status protection and configuration block.
`timescale 1ns/1ps
module testbench;
	logic                            sys_clk = 1'b0;
	logic                            rst = 1'b1;
	logic                            wp = 1'b0;
	logic                            busy = 1'b0;
	logic                            pe_req = 1'b0;
	logic                            pe_prot = 1'b0;
	flash_status_pkg::read_kind_type kind = flash_status_pkg::RK_PLAIN;
	logic                            sck, cs_n, si, so, so_oe, pe_start, lane, ctl, paused, write_latch_flag;
	logic [3:0]                      lock;
	flash_status_pkg::wait_type      rwait;
	logic [7:0]                      rx;
	int                              fail_count = 0;
	int                              tests_run = 0;
	int                              cycles = 0;

	always #5 sys_clk = ~sys_clk;

	spi_host_model host (.clk_i(sys_clk), .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so));

	flash_status_protection_config uut (.sys_clk_i(sys_clk), .rst_i(rst), .sck_i(sck), .cs_n_i(cs_n),
		.si_i(si), .protect_pin_i(wp), .so_o(so), .so_oe_o(so_oe), .busy_i(busy), .pe_req_i(pe_req),
		.pe_region_protected_i(pe_prot), .pe_start_o(pe_start), .read_kind_i(kind), .read_wait_o(rwait),
		.four_lane_enable_o(lane), .control_pins_active_o(ctl), .otp_lock_bits_o(lock),
		.paused_operation_flag_o(paused), .write_latch_flag_o(write_latch_flag));

	task automatic summarize();
		$display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// A hang of the serial framing ends the run as a failure.
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			fail_count++;
			summarize();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cmd(input logic [7:0] c);
		host.xfer({c, 24'h0}, 1, rx);
	endtask

	task automatic rd(input logic [7:0] c, input logic [7:0] exp);
		host.xfer({c, 24'h0}, 2, rx);
		check(rx, exp);
	endtask

	// Every status write is preceded by its own enable frame.
	task automatic wrst(input logic [7:0] en, input logic [23:0] d, input int nb);
		cmd(en);
		host.xfer({8'h01, d}, nb + 1, rx);
	endtask

	task automatic pwr();
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask

	function automatic logic [7:0] exp_wait(input int k, input logic [3:0] n);
		logic [3:0] m;
		logic [3:0] d;
		m = (k == 3) ? flash_status_pkg::DUAL_IO_MODE : (k == 5) ? flash_status_pkg::QUAD_IO_MODE : 4'h0;
		d = (n != 4'h0) ? n : (k == 3) ? 4'h0 : (k == 5) ? flash_status_pkg::QUAD_IO_DUMMY
			: flash_status_pkg::LEGACY_DUMMY;
		if (k == 0) return 8'h00;
		return {m, d};
	endfunction

	task automatic t_reset();
		check(lane, 1'b0);
		check(ctl, 1'b1);
		check(lock, 4'h1);
		check(so_oe, 1'b0);
		rd(8'h35, 8'h04);
		cmd(8'h06);
		check(write_latch_flag, 1'b1);
	endtask

	task automatic t_mode00();
		wrst(8'h06, 24'h7F0200, 2);
		busy <= 1'b1;
		rd(8'h05, 8'h7D);
		busy <= 1'b0;
		check(write_latch_flag, 1'b0);
		check(lane, 1'b1);
		check(ctl, 1'b0);
		wrst(8'h06, 24'h000000, 2);
		check(lane, 1'b0);
	endtask

	task automatic t_mode01();
		wrst(8'h06, 24'h800000, 2);
		wrst(8'h06, 24'h840000, 2);
		rd(8'h05, 8'h80);
		check(write_latch_flag, 1'b0);
		wp <= 1'b1;
		wrst(8'h06, 24'h840000, 2);
		rd(8'h05, 8'h84);
		wrst(8'h06, 24'h000000, 2);
	endtask

	task automatic t_mode10();
		wrst(8'h06, 24'h000100, 2);
		wrst(8'h06, 24'h100000, 2);
		rd(8'h05, 8'h00);
		rd(8'h35, 8'h05);
		cmd(8'h99);
		rd(8'h35, 8'h04);
		wrst(8'h06, 24'h100000, 2);
		rd(8'h05, 8'h10);
		wrst(8'h06, 24'h000000, 2);
	endtask

	task automatic t_pause();
		cmd(8'h75);
		check(paused, 1'b1);
		rd(8'h35, 8'h84);
		wrst(8'h06, 24'h000000, 2);
		check(paused, 1'b1);
		cmd(8'h7A);
		check(paused, 1'b0);
		cmd(8'h75);
		pwr();
		check(paused, 1'b0);
	endtask

	task automatic t_wait();
		logic [3:0] n;
		for (int j = 0; j < 3; j++) begin
			n = (j == 0) ? 4'h0 : (j == 1) ? 4'h1 : 4'hF;
			// The bench link clock is slow, so every count written here is adequate for it.
			wrst(8'h50, {16'h0000, 4'h0, n}, 3);
			for (int k = 0; k < 6; k++) begin
				kind <= flash_status_pkg::read_kind_type'(k);
				repeat (2) @(posedge sys_clk);
				check(rwait, exp_wait(k, n));
			end
		end
	endtask

	task automatic t_lock();
		wrst(8'h06, 24'h000800, 2);
		check(lock, 4'h3);
		wrst(8'h06, 24'h000000, 2);
		check(lock, 4'h3);
		wrst(8'h50, 24'h001000, 3);
		check(lock, 4'h3);
	endtask

	task automatic t_mode11();
		wrst(8'h06, 24'h800100, 2);
		wrst(8'h06, 24'h000000, 2);
		rd(8'h05, 8'h80);
		wrst(8'h50, 24'h000005, 3);
		rd(8'h33, 8'h05);
		rd(8'h35, 8'h0D);
		pwr();
		rd(8'h35, 8'h04);
	endtask

	task automatic t_array();
		@(posedge sys_clk);
		pe_req <= 1'b1;
		pe_prot <= 1'b1;
		@(negedge sys_clk);
		check(pe_start, 1'b0);
		@(posedge sys_clk);
		pe_prot <= 1'b0;
		@(negedge sys_clk);
		check(pe_start, 1'b1);
		@(posedge sys_clk);
		pe_req <= 1'b0;
		@(negedge sys_clk);
		check(pe_start, 1'b0);
	endtask

	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		t_reset();
		t_mode00();
		t_mode01();
		t_mode10();
		t_pause();
		t_wait();
		t_lock();
		t_mode11();
		t_array();
		summarize();
	end
endmodule
